// File: hdl/clear_complement_pkg.sv
// constants for the clear / complement / watchdog-restart decoder
package clear_complement_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] ADDR_INSTR  = 8'h00;
    localparam logic [7:0] ADDR_ACCUM  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FADDR  = 8'h0c;
    localparam logic [7:0] ADDR_FDATA  = 8'h10;
    // instruction encodings
    localparam int          INSTR_W        = 14;
    localparam logic [6:0]  CLEAR_FILE_HI  = 7'h03;
    localparam logic [13:0] CLEAR_ACC_CODE = 14'h0103;
    localparam logic [13:0] WDT_CODE       = 14'h0064;
    localparam logic [5:0]  COMPLEMENT_HI  = 6'h09;
    localparam int          DEST_BIT       = 7;
    // status bit positions
    localparam int ST_ZERO    = 0;
    localparam int ST_PD      = 1;
    localparam int ST_TO      = 2;
    localparam int ST_UNKNOWN = 3;
    // values after reset
    localparam logic [13:0] RST_INSTR   = 14'h0000;
    localparam logic [7:0]  RST_ACCUM   = 8'h00;
    localparam logic [6:0]  RST_FADDR   = 7'h00;
    localparam logic        RST_ZERO    = 1'b0;
    localparam logic        RST_TIMEOUT = 1'b1;
    localparam logic        RST_PD      = 1'b1;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_EXEC = 2'b10,
        S_DONE = 2'b11
    } seq_state_t;
endpackage : clear_complement_pkg

// File: hdl/file_mem.sv
// file register memory with registered read data
`timescale 1ns/100ps
module file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [2**AW];

    // read before write: a same-address read returns the old word
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule : file_mem

// File: hdl/clear_complement_ops.sv
// decode and execute of clear, clear-w, watchdog restart and complement
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module clear_complement_ops
    import clear_complement_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        wdt_timeout_i,
    input  wire logic        sleep_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             wdt_clear_o,
    output logic             prescale_clear_o
);
    seq_state_t    state_q, state_d;
    logic [5:0]    adr_q, adr_d;
    logic          we_q, we_d;
    logic [31:0]   wd_q, wd_d;
    logic [3:0]    sel_q, sel_d;
    logic [31:0]   rd_q, rd_d;
    logic          ack_q, ack_d;
    logic [13:0]   instr_q, instr_d;
    logic [7:0]    accum_q, accum_d;
    logic [6:0]    faddr_q, faddr_d;
    logic          zero_q, zero_d;
    logic          timeout_q, timeout_d;
    logic          powerdown_q, powerdown_d;
    logic          unknown_q, unknown_d;
    logic          wdclr_q, wdclr_d;
    logic          psclr_q, psclr_d;
    logic          mem_we;
    logic [6:0]    mem_waddr;
    logic [7:0]    mem_wdata;
    logic [6:0]    mem_raddr;
    logic [7:0]    mem_rdata;
    logic [7:0]    adr_byte;
    logic [31:0]   byte_mask;
    logic [13:0]   instr_new;
    logic          exec;
    logic          issue;
    logic          op_clear_file_op;
    logic          op_clear_accumulator_op;
    logic          op_wdt;
    logic          op_complement_file_op;
    logic          dest_file;
    logic [7:0]    comp;

    assign adr_byte  = {adr_q, 2'b00};
    assign byte_mask = {{8{sel_q[3]}}, {8{sel_q[2]}},
                        {8{sel_q[1]}}, {8{sel_q[0]}}};
    assign exec      = (state_q == S_EXEC);
    assign issue     = exec && we_q && (adr_byte == ADDR_INSTR);
    assign instr_new = (instr_q & ~byte_mask[13:0])
                     | (wd_q[13:0] & byte_mask[13:0]);
    assign op_clear_file_op   = issue && (instr_new[13:7] == CLEAR_FILE_HI);
    assign op_clear_accumulator_op   = issue && (instr_new == CLEAR_ACC_CODE);
    assign op_wdt    = issue && (instr_new == WDT_CODE);
    assign op_complement_file_op   = issue && (instr_new[13:8] == COMPLEMENT_HI);
    assign dest_file = instr_new[DEST_BIT];
    assign comp      = ~mem_rdata;
    // the file operand is read during S_READ, so it is ready in S_EXEC
    assign mem_raddr = (adr_byte == ADDR_INSTR) ? instr_new[6:0] : faddr_q;

    file_mem #(
        .AW (7),
        .DW (8)
    ) u_file_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        state_d     = state_q;
        adr_d       = adr_q;
        we_d        = we_q;
        wd_d        = wd_q;
        sel_d       = sel_q;
        rd_d        = rd_q;
        ack_d       = 1'b0;
        instr_d     = instr_q;
        accum_d     = accum_q;
        faddr_d     = faddr_q;
        zero_d      = zero_q;
        timeout_d   = timeout_q;
        powerdown_d = powerdown_q;
        unknown_d   = unknown_q;
        wdclr_d     = 1'b0;
        psclr_d     = 1'b0;
        mem_we      = 1'b0;
        mem_waddr   = faddr_q;
        mem_wdata   = wd_q[7:0];
        unique case (state_q)
            S_IDLE: begin
                if (cyc_i && stb_i) begin
                    adr_d   = adr_i[7:2];
                    we_d    = we_i;
                    wd_d    = dat_i;
                    sel_d   = sel_i;
                    state_d = S_READ;
                end
            end
            S_READ: begin
                state_d = S_EXEC;
            end
            S_EXEC: begin
                ack_d   = 1'b1;
                state_d = S_DONE;
                unique case (adr_byte)
                    ADDR_INSTR:  rd_d = {18'h0, instr_q};
                    ADDR_ACCUM:  rd_d = {24'h0, accum_q};
                    ADDR_STATUS: rd_d = {28'h0, unknown_q, timeout_q,
                                         powerdown_q, zero_q};
                    ADDR_FADDR:  rd_d = {25'h0, faddr_q};
                    ADDR_FDATA:  rd_d = {24'h0, mem_rdata};
                    default:     rd_d = 32'h0;
                endcase
                if (we_q) begin
                    unique case (adr_byte)
                        ADDR_INSTR: instr_d = instr_new;
                        ADDR_ACCUM: begin
                            if (sel_q[0]) begin
                                accum_d = wd_q[7:0];
                            end
                        end
                        ADDR_STATUS: begin
                            if (sel_q[0]) begin
                                zero_d = wd_q[ST_ZERO];
                                // write one to clear, sticky otherwise
                                if (wd_q[ST_UNKNOWN]) begin
                                    unknown_d = 1'b0;
                                end
                            end
                        end
                        ADDR_FADDR: begin
                            if (sel_q[0]) begin
                                faddr_d = wd_q[6:0];
                            end
                        end
                        ADDR_FDATA: mem_we = sel_q[0];
                        default: ;
                    endcase
                end
            end
            S_DONE: begin
                state_d = S_IDLE;
            end
        endcase
        if (op_clear_file_op) begin
            mem_we    = 1'b1;
            mem_waddr = instr_new[6:0];
            mem_wdata = 8'h00;
            zero_d    = 1'b1;
        end
        if (op_clear_accumulator_op) begin
            accum_d = 8'h00;
            zero_d  = 1'b1;
        end
        if (op_complement_file_op) begin
            zero_d = (comp == 8'h00);
            if (dest_file) begin
                mem_we    = 1'b1;
                mem_waddr = instr_new[6:0];
                mem_wdata = comp;
            end else begin
                accum_d = comp;
            end
        end
        if (issue && !(op_clear_file_op || op_clear_accumulator_op || op_wdt || op_complement_file_op)) begin
            unknown_d = 1'b1;
        end
        // the far side clears; a restart in the same cycle wins
        if (wdt_timeout_i) begin
            timeout_d = 1'b0;
        end
        if (sleep_i) begin
            powerdown_d = 1'b0;
        end
        if (op_wdt) begin
            wdclr_d     = 1'b1;
            psclr_d     = 1'b1;
            timeout_d   = 1'b1;
            powerdown_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= S_IDLE;
            adr_q       <= 6'h00;
            we_q        <= 1'b0;
            wd_q        <= 32'h0;
            sel_q       <= 4'h0;
            rd_q        <= 32'h0;
            ack_q       <= 1'b0;
            instr_q     <= RST_INSTR;
            accum_q     <= RST_ACCUM;
            faddr_q     <= RST_FADDR;
            zero_q      <= RST_ZERO;
            timeout_q   <= RST_TIMEOUT;
            powerdown_q <= RST_PD;
            unknown_q   <= 1'b0;
            wdclr_q     <= 1'b0;
            psclr_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            adr_q       <= adr_d;
            we_q        <= we_d;
            wd_q        <= wd_d;
            sel_q       <= sel_d;
            rd_q        <= rd_d;
            ack_q       <= ack_d;
            instr_q     <= instr_d;
            accum_q     <= accum_d;
            faddr_q     <= faddr_d;
            zero_q      <= zero_d;
            timeout_q   <= timeout_d;
            powerdown_q <= powerdown_d;
            unknown_q   <= unknown_d;
            wdclr_q     <= wdclr_d;
            psclr_q     <= psclr_d;
        end
    end

    assign dat_o            = rd_q;
    assign ack_o            = ack_q;
    assign wdt_clear_o      = wdclr_q;
    assign prescale_clear_o = psclr_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence instr_req_s;
        state_q == S_IDLE && cyc_i && stb_i && we_i
            && {adr_i[7:2], 2'b00} == ADDR_INSTR;
    endsequence
    sequence exec_done_s;
        state_q == S_READ ##1 state_q == S_EXEC ##1 ack_o ##1 !ack_o;
    endsequence

    clear_file_a: assert property (
        op_clear_file_op |-> mem_we && mem_wdata == 8'h00
            && mem_waddr == instr_new[6:0] ##1 zero_q && ack_o)
        else $error("clear of file register failed");
    wdt_restart_a: assert property (
        op_wdt |=> wdt_clear_o ##1 !wdt_clear_o)
        else $error("watchdog restart pulse missing");
    prescale_clear_a: assert property (
        op_wdt |=> prescale_clear_o && wdt_clear_o)
        else $error("prescaler clear missing");
    restart_flags_a: assert property (
        op_wdt |=> timeout_q && powerdown_q
            && zero_q == $past(zero_q) && accum_q == $past(accum_q))
        else $error("restart flags wrong");
    comp_accum_a: assert property (
        op_complement_file_op && !dest_file |=> accum_q == ~$past(mem_rdata)
            && zero_q == ($past(mem_rdata) == 8'hff))
        else $error("complement to accumulator wrong");
    comp_file_a: assert property (
        op_complement_file_op && dest_file |-> mem_we && mem_wdata == ~mem_rdata
            ##1 accum_q == $past(accum_q))
        else $error("complement to file wrong");
    clear_accum_a: assert property (
        op_clear_accumulator_op |=> accum_q == 8'h00 && zero_q)
        else $error("clear of accumulator failed");
    one_cycle_a: assert property (
        instr_req_s |=> exec_done_s)
        else $error("instruction did not complete in one pass");
endmodule : clear_complement_ops

// File: bench/wdt_model.sv
// behavioural watchdog counter, prescaler and sleep source
`timescale 1ns/100ps
module wdt_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wdt_clear_i,
    input  wire logic       prescale_clear_i,
    input  wire logic       timeout_req_i,
    input  wire logic       sleep_req_i,
    output logic            wdt_timeout_o,
    output logic            sleep_o,
    output logic      [7:0] count_o,
    output logic      [7:0] prescale_o
);
    // counter only steps on prescaler wrap, so a missed clear shows
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o    <= 8'h00;
            prescale_o <= 8'h00;
        end else begin
            prescale_o <= prescale_clear_i ? 8'h00 : prescale_o + 8'h01;
            if (wdt_clear_i)
                count_o <= 8'h00;
            else if (prescale_o == 8'hff)
                count_o <= count_o + 8'h01;
        end
        wdt_timeout_o <= timeout_req_i & ~rst_i;
        sleep_o       <= sleep_req_i & ~rst_i;
    end
endmodule : wdt_model

// File: bench/clear_complement_ops_bench.sv
// self-checking bench for the clear / complement / restart decoder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module clear_complement_ops_bench;
    import clear_complement_pkg::*;
    localparam logic [31:0] TOPD = (32'h1 << ST_TO) | (32'h1 << ST_PD);
    localparam logic [31:0] ZF   = 32'h1 << ST_ZERO;
    localparam logic [31:0] UNK  = 32'h1 << ST_UNKNOWN;
    logic clk_i, rst_i, we, cyc, stb, to_req, slp_req, tmo, slp, ack_o;
    logic wdt_clear_o, prescale_clear_o;
    logic [7:0]  adr, cnt, psc;
    logic [31:0] dat, dat_o, r;
    logic [3:0]  sel;
    int          num_errors, n_checks, n_clr, n_psc;

    clear_complement_ops DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
        .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
        .wdt_timeout_i(tmo), .sleep_i(slp), .dat_o(dat_o), .ack_o(ack_o),
        .wdt_clear_o(wdt_clear_o), .prescale_clear_o(prescale_clear_o));
    wdt_model far_end (.clk_i(clk_i), .rst_i(rst_i),
        .wdt_clear_i(wdt_clear_o), .prescale_clear_i(prescale_clear_o),
        .timeout_req_i(to_req), .sleep_req_i(slp_req), .wdt_timeout_o(tmo),
        .sleep_o(slp), .count_o(cnt), .prescale_o(psc));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (wdt_clear_o === 1'b1) n_clr++;
        if (prescale_clear_o === 1'b1) n_psc++;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // classic cycle: hold everything until ack is sampled at an edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        `CHK("ack", 1'b1, ack_o)
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string nm);
        wb(1'b0, a, 32'h0);
        `CHK(nm, e, r)
    endtask : rd_chk

    task automatic t_reset;
        rd_chk(ADDR_STATUS, TOPD, "status");
        rd_chk(8'h20, 32'h0, "unmapped");
        // an opcode outside the four sets the sticky unknown bit
        wb(1'b1, ADDR_INSTR, 32'h0);
        rd_chk(ADDR_STATUS, TOPD | UNK, "unknown set");
        wb(1'b1, ADDR_STATUS, UNK);
        rd_chk(ADDR_STATUS, TOPD, "unknown clear");
    endtask : t_reset

    task automatic t_clear_file;
        wb(1'b1, ADDR_FADDR, 32'h7f);
        wb(1'b1, ADDR_FDATA, 32'h5a);
        rd_chk(ADDR_FDATA, 32'h5a, "file before");
        wb(1'b1, ADDR_STATUS, 32'h0);
        wb(1'b1, ADDR_INSTR, 32'({CLEAR_FILE_HI, 7'h7f}));
        rd_chk(ADDR_FDATA, 32'h0, "file");
        rd_chk(ADDR_STATUS, TOPD | ZF, "status");
    endtask : t_clear_file

    task automatic t_clear_w;
        wb(1'b1, ADDR_ACCUM, 32'h5a);
        wb(1'b1, ADDR_STATUS, 32'h0);
        wb(1'b1, ADDR_INSTR, 32'(CLEAR_ACC_CODE));
        rd_chk(ADDR_ACCUM, 32'h0, "accum");
        rd_chk(ADDR_STATUS, TOPD | ZF, "status");
        // lane 0 off: the accumulator byte must not change
        wb(1'b1, ADDR_ACCUM, 32'h77, 4'he);
        rd_chk(ADDR_ACCUM, 32'h0, "lane off");
    endtask : t_clear_w

    task automatic t_complement;
        wb(1'b1, ADDR_FADDR, 32'h05);
        wb(1'b1, ADDR_FDATA, 32'h0f);
        wb(1'b1, ADDR_INSTR, 32'({COMPLEMENT_HI, 1'b0, 7'h05}));
        rd_chk(ADDR_ACCUM, 32'hf0, "accum");
        rd_chk(ADDR_FDATA, 32'h0f, "file");
        rd_chk(ADDR_STATUS, TOPD, "status");
        wb(1'b1, ADDR_INSTR, 32'({COMPLEMENT_HI, 1'b1, 7'h05}));
        rd_chk(ADDR_FDATA, 32'hf0, "file");
        rd_chk(ADDR_ACCUM, 32'hf0, "accum kept");
        wb(1'b1, ADDR_FDATA, 32'hff);
        wb(1'b1, ADDR_INSTR, 32'({COMPLEMENT_HI, 1'b0, 7'h05}));
        rd_chk(ADDR_ACCUM, 32'h0, "accum");
        rd_chk(ADDR_STATUS, TOPD | ZF, "status");
        wb(1'b1, ADDR_STATUS, 32'h0);
        wb(1'b1, ADDR_INSTR, 32'({COMPLEMENT_HI, 1'b1, 7'h05}));
        rd_chk(ADDR_FDATA, 32'h0, "file zero");
        rd_chk(ADDR_STATUS, TOPD | ZF, "status");
    endtask : t_complement

    task automatic t_restart;
        @(posedge clk_i);
        to_req  <= 1'b1;
        slp_req <= 1'b1;
        @(posedge clk_i);
        to_req  <= 1'b0;
        slp_req <= 1'b0;
        rd_chk(ADDR_STATUS, ZF, "flags low");
        repeat (300) @(posedge clk_i);
        `CHK("count ran", 1'b1, cnt != 8'h00)
        wb(1'b1, ADDR_INSTR, 32'(WDT_CODE));
        // pulses are counted and the model clears on the ack edge
        @(posedge clk_i);
        `CHK("wdt pulses", 1, n_clr)
        `CHK("prescale pulses", 1, n_psc)
        `CHK("wdt count", 8'h00, cnt)
        `CHK("prescaler", 8'h00, psc)
        rd_chk(ADDR_STATUS, TOPD | ZF, "status");
    endtask : t_restart

    initial begin
        {we, cyc, stb, to_req, slp_req} = '0;
        {adr, dat, sel, num_errors, n_checks, n_clr, n_psc} = '0;
        sel   = 4'hf;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_clear_file();
        t_clear_w();
        t_complement();
        t_restart();
        stop_test();
    end

    // whole run is near 500 cycles; this limit leaves wide margin
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end
endmodule : clear_complement_ops_bench
